/* src/wss_sequencer.sv */
// Weld schedule sequencer: runs stored schedules on an initiation.
// Assumes operator pins are asynchronous and a mains pulse marks each line cycle.
//
// Notes on behaviour
// - Initiation energises the schedule's valve at the start of squeeze.
// - Squeeze is timed, then weld waits for the pressure switch to close.
// - Weld enables transformer current at programmed heat for programmed weld time.
// - With pulse repeats, weld and cool alternate until count used, then hold.
// - Hold supplies no current and keeps the valve energised.
// - Single-shot has no off time; valve drops when hold ends.
// - One hundred schedules, each with its own sequence type, any may start.
// - Linked schedule N is followed after its off time by N+1 with its own settings.
// - A linked last schedule repeats the chain while initiation stays closed.
// - A single-shot schedule ends a linked run like a single-shot sequence.
// - Each link raises the displayed schedule number by one.
// - A stepped schedule ends the run, advances number, awaits new initiation.
// - Zero hold, off and next squeeze join two welds with no current gap.
// - After a run that does not end on a stepped schedule the display follows the external select or the stored number.
// - Stepped mode runs one schedule per initiation, then advances and idles.
// - Advanced number flashes; after the series ends the first is shown again.
// - External source starts the series at the selected schedule and returns there.
// - Each short step-back closure moves to the previous schedule of the series.
// - Step-back held about 1.5 seconds returns to the series' first schedule.
`timescale 1ns/1ns
module wss_sequencer
  import wss_pkg::*;
#(
  parameter int BACK_HOLD = BACK_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Operator and machine pins
  input  wire wss_pins_t   pins,
  // Valve and transformer drive
  output wss_drive_t       drive,
  // Schedule display
  output wss_disp_t        disp_out
);

  localparam int PW = $bits(wss_pins_t);

  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic [PW-1:0] f;
    logic          mains_prev;
    logic          sb_prev;
    logic [31:0]   sb_cnt;
    wss_state_t    st;
    logic [7:0]    cnt;
    logic [3:0]    pulse_left;
    logic [6:0]    cur;
    logic [6:0]    chain_first;
    logic [6:0]    series_first;
    logic [6:0]    disp;
    logic          in_series;
    logic          armed;
    logic          bridge;
    logic          ctrl_ext;
    logic [6:0]    ctrl_num;
    logic [6:0]    mem_idx;
    logic          mem_hi;
    logic          waitrequest;
    logic [31:0]   rdata;
    wss_drive_t    drv;
    wss_disp_t     dsp;
  } wss_regs_t;

  wss_regs_t   q;
  wss_regs_t   n;
  logic [63:0] sched_mem [NUM_SCHED];

  wss_pins_t   fp;
  wss_sched_t  sc;
  wss_sched_t  sn;
  logic        tick;
  logic        done;
  logic        go;
  logic        finish;
  logic [6:0]  go_idx;
  logic [6:0]  src_sched;
  logic        mem_we;

  function automatic logic [6:0] wss_next(input logic [6:0] i);
    return (i == LAST_SCHED) ? FIRST_SCHED : i + 7'h01;
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    n = q;
    go = 1'b0;
    finish = 1'b0;
    go_idx = q.cur;
    mem_we = 1'b0;
    fp = wss_pins_t'(q.f);
    sc = wss_unpack(sched_mem[q.cur]);
    // Three-stage synchroniser; a change counts once stages two and three agree.
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f  = (q.s2 & q.s3) | (q.f & (q.s2 | q.s3));
    n.mains_prev = fp.mains;
    n.sb_prev = fp.step_back_input;
    tick = fp.mains & ~q.mains_prev;
    done = (q.cnt == 8'h00);
    if (tick && !done) begin
      n.cnt = q.cnt - 8'h01;
    end
    src_sched = q.ctrl_num;
    if (q.ctrl_ext) begin
      src_sched = (fp.external_select_inputs > LAST_SCHED) ? LAST_SCHED
                                                          : fp.external_select_inputs;
    end
    // A held initiation switch must open once before it can start another run.
    if (!fp.initiation) begin
      n.armed = 1'b1;
    end
    // The hold counter saturates so a switch left closed cannot wrap it round.
    if (!fp.step_back_input) begin
      n.sb_cnt = 32'h0000_0000;
    end else if (q.sb_cnt != 32'(BACK_HOLD)) begin
      n.sb_cnt = q.sb_cnt + 32'h0000_0001;
    end

    unique case (q.st)
      ST_IDLE: begin
        if (!q.in_series) begin
          n.disp = src_sched;
        end else if (q.sb_cnt == 32'(BACK_HOLD - 1)) begin
          n.disp = q.series_first;
        end else if (fp.step_back_input && !q.sb_prev && q.disp != q.series_first) begin
          n.disp = q.disp - 7'h01;
        end
        if (fp.initiation && q.armed) begin
          n.armed = 1'b0;
          go = 1'b1;
          go_idx = q.in_series ? q.disp : src_sched;
          n.chain_first = go_idx;
          if (!q.in_series) begin
            n.series_first = go_idx;
          end
        end
      end
      ST_SQUEEZE: begin
        if (done) begin
          n.st = ST_PRESS;
          if (fp.pressure_ok) begin
            n.st = ST_WELD;
            n.cnt = sc.weld;
            n.pulse_left = (sc.pulses == 4'h0) ? 4'h0 : sc.pulses - 4'h1;
          end
        end
      end
      ST_PRESS: begin
        if (fp.pressure_ok) begin
          n.st = ST_WELD;
          n.cnt = sc.weld;
          n.pulse_left = (sc.pulses == 4'h0) ? 4'h0 : sc.pulses - 4'h1;
        end
      end
      ST_WELD: begin
        if (done) begin
          n.bridge = 1'b0;
          if (q.pulse_left != 4'h0) begin
            n.st = ST_COOL;
            n.cnt = sc.cool;
          end else begin
            n.st = ST_HOLD;
            n.cnt = sc.hold;
            // Keep current flowing across zero-length gaps into the next weld.
            n.bridge = (sc.mode == MODE_LINKED) && (sc.hold == 8'h00)
                       && (sc.off == 8'h00);
          end
        end
      end
      ST_COOL: begin
        if (done) begin
          n.st = ST_WELD;
          n.cnt = sc.weld;
          n.pulse_left = q.pulse_left - 4'h1;
        end
      end
      ST_HOLD: begin
        if (done) begin
          if (sc.mode == MODE_LINKED) begin
            n.st = ST_OFF;
            n.cnt = sc.off;
          end else begin
            finish = 1'b1;
            if (sc.mode == MODE_STEPPED) begin
              n.in_series = 1'b1;
              n.disp = wss_next(q.cur);
            end else if (q.in_series) begin
              n.in_series = 1'b0;
              n.disp = q.series_first;
            end else begin
              n.disp = src_sched;
            end
          end
        end
      end
      ST_OFF: begin
        if (done) begin
          if (q.cur != LAST_SCHED) begin
            go = 1'b1;
            go_idx = q.cur + 7'h01;
          end else if (fp.initiation) begin
            go = 1'b1;
            go_idx = q.chain_first;
          end else begin
            finish = 1'b1;
            n.disp = src_sched;
          end
        end
      end
    endcase

    if (finish) begin
      n.st = ST_IDLE;
      n.bridge = 1'b0;
    end
    if (go) begin
      n.cur = go_idx;
      n.disp = go_idx;
    end
    sn = wss_unpack(sched_mem[n.cur]);
    if (go) begin
      n.st = ST_SQUEEZE;
      n.cnt = sn.squeeze;
      n.bridge = q.bridge && (sn.squeeze == 8'h00);
    end
    n.drv.valve_on = (n.st != ST_IDLE);
    n.drv.valve_sel = sn.valve;
    n.drv.weld_en = (n.st == ST_WELD) || n.bridge;
    n.drv.heat = sn.heat;
    // Display flags are registered so the panel never sees a decode glitch.
    n.dsp.sched = n.disp;
    n.dsp.flash = n.in_series && (n.st == ST_IDLE);
    n.dsp.busy = (n.st != ST_IDLE);

    // Avalon slave: one wait cycle, then the answer; writes land on that edge.
    n.waitrequest = 1'b1;
    if ((read || write) && q.waitrequest) begin
      n.waitrequest = 1'b0;
      unique case (address)
        REG_CTRL:     n.rdata = {23'h0, q.ctrl_num, 1'b0, q.ctrl_ext};
        REG_STATUS:   n.rdata = {19'h0, q.st, q.drv.weld_en, q.drv.valve_on,
                                 q.in_series, q.disp};
        REG_MEM_ADDR: n.rdata = {23'h0, q.mem_hi, 1'b0, q.mem_idx};
        REG_MEM_DATA: n.rdata = q.mem_hi ? sched_mem[q.mem_idx][63:32]
                                         : sched_mem[q.mem_idx][31:0];
        default:      n.rdata = READ_ZERO;
      endcase
    end
    if (write && !q.waitrequest) begin
      unique case (address)
        REG_CTRL: begin
          n.ctrl_ext = writedata[0];
          n.ctrl_num = (writedata[8:2] > LAST_SCHED) ? LAST_SCHED : writedata[8:2];
        end
        REG_MEM_ADDR: begin
          n.mem_idx = (writedata[6:0] > LAST_SCHED) ? LAST_SCHED : writedata[6:0];
          n.mem_hi = writedata[8];
        end
        REG_MEM_DATA: mem_we = 1'b1;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl_ext <= CTRL_EXT_RESET;
      q.ctrl_num <= CTRL_NUM_RESET;
      q.waitrequest <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Schedule memory has no reset; software loads it before first use.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      if (q.mem_hi) begin
        sched_mem[q.mem_idx][63:32] <= writedata;
      end else begin
        sched_mem[q.mem_idx][31:0] <= writedata;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign readdata = q.rdata;
  assign waitrequest = q.waitrequest;
  assign drive = q.drv;
  assign disp_out = q.dsp;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence enter_squeeze_s;
    q.st != ST_SQUEEZE ##1 q.st == ST_SQUEEZE;
  endsequence

  sequence hold_ends_s;
    q.st == ST_HOLD && q.cnt == 8'h00;
  endsequence

  valve_on_start_a: assert property (enter_squeeze_s |->
    q.drv.valve_on && q.drv.valve_sel == sc.valve)
    else $error("valve not on at squeeze start");
  press_wait_a: assert property (q.st == ST_PRESS && !fp.pressure_ok |=> q.st == ST_PRESS)
    else $error("weld began with pressure switch open");
  weld_current_a: assert property (q.st == ST_WELD |-> q.drv.weld_en && q.drv.heat == sc.heat)
    else $error("weld interval without current at heat");
  pulse_repeat_a: assert property (q.st == ST_COOL && q.cnt == 8'h00 |=>
    q.st == ST_WELD && q.pulse_left == $past(q.pulse_left) - 4'h1)
    else $error("pulse repeat did not return to weld");
  hold_no_current_a: assert property (q.st == ST_HOLD && !q.bridge |->
    !q.drv.weld_en && q.drv.valve_on)
    else $error("hold interval drive wrong");
  single_end_a: assert property (hold_ends_s and sc.mode == MODE_SINGLE |=>
    q.st == ST_IDLE && !q.drv.valve_on)
    else $error("single-shot did not release valve");
  link_next_a: assert property (q.st == ST_OFF && q.cnt == 8'h00 && q.cur != LAST_SCHED |=>
    q.st == ST_SQUEEZE && q.cur == $past(q.cur) + 7'h01 && q.disp == q.cur)
    else $error("linked run did not advance");
  step_advance_a: assert property (hold_ends_s and sc.mode == MODE_STEPPED |=>
    q.st == ST_IDLE && q.in_series && q.disp == wss_next($past(q.cur)))
    else $error("stepped schedule did not advance");
  interval_tick_a: assert property (q.st == ST_WELD && q.cnt > 8'h01 && !tick |=>
    q.cnt == $past(q.cnt))
    else $error("interval counted without mains cycle");
  chain_repeat_a: assert property (q.st == ST_OFF && q.cnt == 8'h00 && q.cur == LAST_SCHED
    && fp.initiation |=> q.st == ST_SQUEEZE && q.cur == q.chain_first)
    else $error("linked chain did not restart");
  gap_bridge_a: assert property (q.st == ST_OFF && q.cnt == 8'h00 && q.bridge
    && q.cur != LAST_SCHED |=> q.drv.weld_en == (sc.squeeze == 8'h00))
    else $error("zero-gap link dropped weld current");
  step_back_a: assert property (q.st == ST_IDLE && q.in_series && !fp.initiation
    && fp.step_back_input && !q.sb_prev && q.disp != q.series_first
    && q.sb_cnt != 32'(BACK_HOLD - 1) |=> q.disp == $past(q.disp) - 7'h01)
    else $error("step-back did not move one schedule back");
  back_hold_a: assert property (q.st == ST_IDLE && q.in_series && !fp.initiation
    && q.sb_cnt == 32'(BACK_HOLD - 1) |=> q.disp == q.series_first)
    else $error("held step-back did not return to first schedule");
  disp_follow_a: assert property (q.st == ST_IDLE && !q.in_series |=>
    q.disp == $past(src_sched))
    else $error("idle display does not follow program source");
  ext_start_a: assert property (q.st == ST_IDLE && !q.in_series && q.armed
    && fp.initiation |=> q.st == ST_SQUEEZE && q.cur == $past(src_sched))
    else $error("run did not start at the selected schedule");
  series_end_a: assert property (hold_ends_s and sc.mode == MODE_SINGLE
    && q.in_series |=> !q.in_series && q.disp == q.series_first)
    else $error("series end did not show first schedule");
  interval_step_a: assert property ((q.st == ST_COOL || q.st == ST_HOLD)
    && q.cnt != 8'h00 && tick |=> q.cnt == $past(q.cnt) - 8'h01)
    else $error("interval did not count a mains cycle");

endmodule

/* pkg/wss_pkg.sv */
// Shared constants and types for the weld schedule sequencer.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register slave.
package wss_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ         = 250_000_000;
  localparam int BACK_HOLD_MS   = 1500;
  localparam int BACK_HOLD_CYC  = (CLK_HZ / 1000) * BACK_HOLD_MS;

  // ==========================================================================
  // Schedule store
  localparam int         NUM_SCHED  = 100;
  localparam logic [6:0] FIRST_SCHED = 7'h00;
  localparam logic [6:0] LAST_SCHED  = 7'h63;

  localparam logic [1:0] MODE_SINGLE  = 2'h0;
  localparam logic [1:0] MODE_LINKED  = 2'h1;
  localparam logic [1:0] MODE_STEPPED = 2'h2;

  // Field positions inside the 64-bit schedule word (low word, then high word).
  localparam int POS_SQUEEZE = 0;
  localparam int POS_WELD    = 8;
  localparam int POS_COOL    = 16;
  localparam int POS_HOLD    = 24;
  localparam int POS_OFF     = 32;
  localparam int POS_HEAT    = 40;
  localparam int POS_PULSES  = 48;
  localparam int POS_VALVE   = 52;
  localparam int POS_MODE    = 56;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_MEM_ADDR = 4'h8;
  localparam logic [3:0] REG_MEM_DATA = 4'hC;

  localparam logic [6:0]  CTRL_NUM_RESET = 7'h00;
  localparam logic        CTRL_EXT_RESET = 1'b0;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] valve;
    logic [3:0] pulses;
    logic [7:0] heat;
    logic [7:0] off;
    logic [7:0] hold;
    logic [7:0] cool;
    logic [7:0] weld;
    logic [7:0] squeeze;
  } wss_sched_t;

  typedef struct packed {
    logic       initiation;
    logic       pressure_ok;
    logic       step_back_input;
    logic       mains;
    logic [6:0] external_select_inputs;
  } wss_pins_t;

  typedef struct packed {
    logic       valve_on;
    logic [2:0] valve_sel;
    logic       weld_en;
    logic [7:0] heat;
  } wss_drive_t;

  typedef struct packed {
    logic [6:0] sched;
    logic       flash;
    logic       busy;
  } wss_disp_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SQUEEZE, ST_PRESS, ST_WELD, ST_COOL, ST_HOLD, ST_OFF
  } wss_state_t;

  function automatic wss_sched_t wss_unpack(input logic [63:0] w);
    wss_sched_t s;
    s.squeeze = w[POS_SQUEEZE +: 8];
    s.weld    = w[POS_WELD +: 8];
    s.cool    = w[POS_COOL +: 8];
    s.hold    = w[POS_HOLD +: 8];
    s.off     = w[POS_OFF +: 8];
    s.heat    = w[POS_HEAT +: 8];
    s.pulses  = w[POS_PULSES +: 4];
    s.valve   = w[POS_VALVE +: 3];
    s.mode    = w[POS_MODE +: 2];
    return s;
  endfunction

endpackage

/* tb/wss_far_model.sv */
// Far-side model: operator switches, mains line, pressure switch behind the valve.
// Assumes the bench commands the switches and reads the sequencer drive outputs.
`timescale 1ns/1ns
module wss_far_model
  import wss_pkg::*;
#(
  parameter int MAINS_HALF = 10
) (
  // Clock
  input  wire logic        clk,
  // Bench commands
  input  wire logic        init_cmd,
  input  wire logic        back_cmd,
  input  wire logic [6:0]  sel_cmd,
  input  wire logic [15:0] press_dly,
  // Machine side
  input  wire wss_drive_t  drive,
  output wss_pins_t        pins
);
  int ph;
  int pc;

  initial begin
    pins = '0;
    ph   = 0;
    pc   = 0;
  end

  // ==========================================================================
  // Switches and line
  // The pressure switch closes only once the valve has had time to build force.
  always @(posedge clk) begin
    ph                          <= (ph == 2 * MAINS_HALF - 1) ? 0 : ph + 1;
    pins.mains                  <= (ph < MAINS_HALF);
    pins.initiation             <= init_cmd;
    pins.step_back_input        <= back_cmd;
    pins.external_select_inputs <= sel_cmd;
    if (!drive.valve_on) begin
      pc <= 0;
    end else if (pc < int'(press_dly)) begin
      pc <= pc + 1;
    end
    pins.pressure_ok <= drive.valve_on && (pc >= int'(press_dly));
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the weld schedule sequencer.
// Assumes the far-side model supplies mains pulses and the pressure switch.
`timescale 1ns/1ns
module tb;
  import wss_pkg::*;
  localparam int BH = 50;
  logic        clk;
  logic        reset_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  wss_pins_t   pins;
  wss_drive_t  drive;
  wss_disp_t   disp_out;
  logic        init_cmd;
  logic        back_cmd;
  logic [6:0]  sel_cmd;
  logic [15:0] press_dly;
  logic [31:0] q;
  logic [7:0]  ht_exp;
  logic [2:0]  vs_exp;
  logic [6:0]  k;
  logic        saw11;
  logic        prev_w;
  wss_sched_t  s;
  int          bad_count;
  int          cmp_count;
  int          seed;
  int          wrises;
  int          wlen;
  int          last_wlen;

  wss_sequencer #(.BACK_HOLD(BH)) dut_u (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pins(pins), .drive(drive), .disp_out(disp_out));
  wss_far_model far_u (.clk(clk), .init_cmd(init_cmd), .back_cmd(back_cmd), .sel_cmd(sel_cmd),
    .press_dly(press_dly), .drive(drive), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (disp_out.busy !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (disp_out.busy !== v) begin
      chk("busy_wait", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  // The request stands until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (waitrequest !== 1'b0) begin
      chk("bus_wait", 32'h0, 32'h1);
      report_and_stop();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    // One idle edge keeps a following call from driving a strobe twice in one step.
    @(posedge clk);
  endtask

  task automatic wr_sched(input logic [6:0] i, input wss_sched_t t);
    bus(1'b1, REG_MEM_ADDR, {23'h0, 1'b0, 1'b0, i});
    bus(1'b1, REG_MEM_DATA, {t.hold, t.cool, t.weld, t.squeeze});
    bus(1'b1, REG_MEM_ADDR, {23'h0, 1'b1, 1'b0, i});
    bus(1'b1, REG_MEM_DATA, {6'h0, t.mode, 1'b0, t.valve, t.pulses, t.heat, t.off});
  endtask

  task automatic fire(input int bursts);
    wrises = 0;
    init_cmd <= 1'b1;
    wait_busy(1'b1, 500);
    init_cmd <= 1'b0;
    wait_busy(1'b0, 20000);
    repeat (4) @(posedge clk);
    chk("weld_bursts", wrises, bursts);
    chk("valve_after", drive.valve_on, 32'h0);
  endtask

  task automatic chk_disp(input logic [6:0] sch, input logic fl);
    chk("disp_sched", disp_out.sched, sch);
    chk("disp_flash", disp_out.flash, fl);
  endtask

  function automatic logic [6:0] nxt(input logic [6:0] i);
    return (i == LAST_SCHED) ? FIRST_SCHED : i + 7'h01;
  endfunction

  task automatic back(input int n);
    back_cmd <= 1'b1;
    repeat (n) @(posedge clk);
    back_cmd <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // ==========================================================================
  // Drive monitor
  always @(posedge clk) begin
    prev_w <= drive.weld_en;
    if (drive.weld_en) begin
      wlen <= wlen + 1;
      chk("weld_heat", drive.heat, ht_exp);
      chk("valve_sel", drive.valve_sel, vs_exp);
      chk("valve_in_weld", drive.valve_on, 32'h1);
    end
    if (drive.weld_en && !prev_w) begin
      wrises <= wrises + 1;
      wlen   <= 1;
      chk("press_before_weld", pins.pressure_ok, 32'h1);
    end
    if (!drive.weld_en && prev_w) begin
      last_wlen <= wlen;
    end
    if (disp_out.sched == 7'h0B && disp_out.busy) begin
      saw11 <= 1'b1;
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 91212;
    bad_count = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    {read, write, init_cmd, back_cmd, prev_w, saw11} = '0;
    address = 4'h0;
    writedata = 32'h0;
    sel_cmd = 7'h14;
    press_dly = 16'h0001;
    {wrises, wlen, last_wlen} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_reset", q, {23'h0, CTRL_NUM_RESET, 1'b0, CTRL_EXT_RESET});
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, READ_ZERO);
    s = '{MODE_STEPPED, 3'h5, 4'h7, 8'hA5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    wr_sched(LAST_SCHED, s);
    bus(1'b0, REG_MEM_DATA, 32'h0);
    chk("mem_top", q, {6'h0, s.mode, 1'b0, s.valve, s.pulses, s.heat, s.off});
    // Single shot with three bursts while the pressure switch is slow.
    ht_exp = 8'($random(seed));
    vs_exp = 3'($random(seed));
    wr_sched(7'h05, '{MODE_SINGLE, vs_exp, 4'h3, ht_exp, 8'h0, 8'h02, 8'h01, 8'h03, 8'h02});
    bus(1'b1, REG_CTRL, {23'h0, 7'h05, 2'b00});
    press_dly <= 16'h012C;
    fire(3);
    chk("weld_len", (last_wlen >= 40 && last_wlen <= 80), 32'h1);
    press_dly <= 16'h0001;
    // Linked pair whose welds join with no gap.
    wr_sched(7'h0A, '{MODE_LINKED, vs_exp, 4'h1, ht_exp, 8'h0, 8'h0, 8'h0, 8'h02, 8'h01});
    wr_sched(7'h0B, '{MODE_SINGLE, vs_exp, 4'h1, ht_exp, 8'h0, 8'h01, 8'h0, 8'h02, 8'h0});
    bus(1'b1, REG_CTRL, {23'h0, 7'h0A, 2'b00});
    fire(1);
    chk("link_shown", saw11, 32'h1);
    chk("link_end", disp_out.sched, 7'h0A);
    // Linked top schedule repeats its chain while the initiation stays closed.
    wr_sched(LAST_SCHED, '{MODE_LINKED, vs_exp, 4'h1, ht_exp, 8'h01, 8'h01, 8'h0, 8'h01, 8'h01});
    bus(1'b1, REG_CTRL, {23'h0, LAST_SCHED, 2'b00});
    wrises = 0;
    init_cmd <= 1'b1;
    repeat (300) @(posedge clk);
    init_cmd <= 1'b0;
    wait_busy(1'b0, 20000);
    repeat (4) @(posedge clk);
    chk("chain_repeat", wrises > 1, 32'h1);
    chk("chain_valve", drive.valve_on, 32'h0);
    chk("chain_end", disp_out.sched, LAST_SCHED);
    // Stepped series of three.
    for (k = 7'h14; k < 7'h17; k++) begin
      wr_sched(k, '{(k == 7'h16) ? MODE_SINGLE : MODE_STEPPED, vs_exp, 4'h1, ht_exp,
                    8'h0, 8'h01, 8'h0, 8'h01, 8'h01});
    end
    bus(1'b1, REG_CTRL, {23'h0, 7'h14, 2'b00});
    fire(1);
    chk_disp(nxt(7'h14), 1'b1);
    back(20);
    chk_disp(7'h14, 1'b1);
    fire(1);
    fire(1);
    chk_disp(nxt(7'h15), 1'b1);
    back(100);
    chk_disp(7'h14, 1'b1);
    fire(1);
    fire(1);
    fire(1);
    chk_disp(7'h14, 1'b0);
    sel_cmd <= 7'h15;
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    fire(1);
    chk_disp(nxt(7'h15), 1'b1);
    fire(1);
    chk_disp(7'h15, 1'b0);
    report_and_stop();
  end
endmodule
